// *** arpc_pkg.sv ***
// Constants, field layouts and types of the accelerometer register bank.
// Assumes a single 50 MHz core clock shared by the whole bank.
package arpc_pkg;

    // ------------------------------------------------------------------
    // Clock and bus widths
    // ------------------------------------------------------------------
    localparam longint CLK_HZ = 64'd50_000_000;
    localparam int     ADDR_W = 7;
    localparam int     DATA_W = 8;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_DEVICE_ID = 7'h0f;
    localparam logic [6:0] ADDR_HP_CLEAR  = 7'h25;
    localparam logic [6:0] ADDR_STATUS    = 7'h27;
    localparam logic [6:0] ADDR_EV1_SRC   = 7'h31;
    localparam logic [6:0] ADDR_EV2_SRC   = 7'h35;
    localparam logic [2:0][6:0] OUT_ADDR  = {7'h2d, 7'h2b, 7'h29};

    // Reserved calibration locations
    localparam logic [6:0] RSV_A_LO = 7'h00;
    localparam logic [6:0] RSV_A_HI = 7'h0e;
    localparam logic [6:0] RSV_B_LO = 7'h10;
    localparam logic [6:0] RSV_B_HI = 7'h1f;
    localparam logic [6:0] RSV_C_LO = 7'h38;
    localparam logic [6:0] RSV_C_HI = 7'h3f;
    localparam logic [6:0] RSV_GAP0 = 7'h28;
    localparam logic [6:0] RSV_GAP1 = 7'h2a;
    localparam logic [6:0] RSV_GAP2 = 7'h2c;
    localparam logic [6:0] RSV_GAP3 = 7'h2e;
    localparam logic [6:0] RSV_GAP4 = 7'h2f;
    localparam int         CAL_DEPTH = 64;

    // Sub-address byte: top bit asks for address auto-increment
    localparam int SUB_INC_BIT = 7;

    // ------------------------------------------------------------------
    // Read/write control registers, index order of the register file
    // ------------------------------------------------------------------
    localparam int RW_COUNT     = 12;
    localparam int RW_IDX_CTRL1 = 0;
    localparam logic [11:0][6:0] RW_ADDR = {
        7'h37, 7'h36, 7'h34, 7'h33, 7'h32, 7'h30,
        7'h26, 7'h24, 7'h23, 7'h22, 7'h21, 7'h20};
    localparam logic [11:0][7:0] RW_RESET = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};

    // Power, rate and axis control field positions
    localparam int PM_MSB  = 7;
    localparam int PM_LSB  = 5;
    localparam int DR_MSB  = 4;
    localparam int DR_LSB  = 3;
    localparam int AXE_MSB = 2;
    localparam int AXE_LSB = 0;

    // Power mode codes
    localparam logic [2:0] PM_POWER_DOWN = 3'h0;
    localparam logic [2:0] PM_NORMAL     = 3'h1;
    localparam logic [2:0] PM_LP_FIRST   = 3'h2;
    localparam logic [2:0] PM_LP_LAST    = 3'h6;

    // Status byte layout
    localparam int STATUS_ANY_NEW_BIT = 3;
    localparam int STATUS_ANY_OVR_BIT = 7;

    // ------------------------------------------------------------------
    // Output rates in millihertz and sample periods in core cycles
    // ------------------------------------------------------------------
    localparam longint RATE_N50_MHZ  = 64'd50_000;
    localparam longint RATE_N100_MHZ = 64'd100_000;
    localparam longint RATE_N400_MHZ = 64'd400_000;
    localparam longint RATE_N1K_MHZ  = 64'd1_000_000;
    localparam longint RATE_LP0_MHZ  = 64'd500;
    localparam longint RATE_LP1_MHZ  = 64'd1_000;
    localparam longint RATE_LP2_MHZ  = 64'd2_000;
    localparam longint RATE_LP5_MHZ  = 64'd5_000;
    localparam longint RATE_LP10_MHZ = 64'd10_000;

    typedef logic [3:0][31:0] arpc_norm_tbl_t;
    typedef logic [4:0][31:0] arpc_lp_tbl_t;

    localparam arpc_norm_tbl_t NORM_PERIOD_DEF = {
        32'(CLK_HZ * 1000 / RATE_N1K_MHZ),
        32'(CLK_HZ * 1000 / RATE_N400_MHZ),
        32'(CLK_HZ * 1000 / RATE_N100_MHZ),
        32'(CLK_HZ * 1000 / RATE_N50_MHZ)};
    localparam arpc_lp_tbl_t LP_PERIOD_DEF = {
        32'(CLK_HZ * 1000 / RATE_LP10_MHZ),
        32'(CLK_HZ * 1000 / RATE_LP5_MHZ),
        32'(CLK_HZ * 1000 / RATE_LP2_MHZ),
        32'(CLK_HZ * 1000 / RATE_LP1_MHZ),
        32'(CLK_HZ * 1000 / RATE_LP0_MHZ)};

    // Calibration restore sequencer
    typedef enum logic {RESTORE_LOADING, RESTORE_DONE} arpc_restore_t;

    function automatic logic arpc_is_reserved(input logic [6:0] a);
        return (a >= RSV_A_LO && a <= RSV_A_HI)
            || (a >= RSV_B_LO && a <= RSV_B_HI)
            || (a >= RSV_C_LO && a <= RSV_C_HI)
            || a == RSV_GAP0 || a == RSV_GAP1 || a == RSV_GAP2
            || a == RSV_GAP3 || a == RSV_GAP4;
    endfunction : arpc_is_reserved

endpackage : arpc_pkg

// *** arpc_rate_if.sv ***
// Carrier between the register bank and its sample rate generator.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface arpc_rate_if;
    logic [2:0] powerMode;
    logic [1:0] rateSel;
    logic       sampleTick;
    logic       powerDown;
    logic       lowPowerActive;

    modport gen
    (
        input  powerMode,
        input  rateSel,
        output sampleTick,
        output powerDown,
        output lowPowerActive
    );

    modport bank
    (
        output powerMode,
        output rateSel,
        input  sampleTick,
        input  powerDown,
        input  lowPowerActive
    );
endinterface : arpc_rate_if

// *** arpc_rate_gen.sv ***
// Sample strobe generator driven by the power mode and rate fields.
// Assumes the fields come from flops on the same core clock.
`timescale 1ns/1ps
module arpc_rate_gen
    import arpc_pkg::*;
#(
    parameter arpc_norm_tbl_t NormPeriod = NORM_PERIOD_DEF,
    parameter arpc_lp_tbl_t   LowPeriod  = LP_PERIOD_DEF
)
(
    input wire logic   core_clk,
    input wire logic   sys_rst,
    arpc_rate_if.gen   rif
);

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic        tick_q;

    // Code 111 is undefined; treated as power-down so nothing samples
    wire         isNormal = rif.powerMode == PM_NORMAL;
    wire         isLow    = rif.powerMode >= PM_LP_FIRST
                         && rif.powerMode <= PM_LP_LAST;
    wire         running  = isNormal || isLow;
    wire [2:0]   lpDelta  = 3'(rif.powerMode - PM_LP_FIRST);
    wire [2:0]   lpIndex  = isLow ? lpDelta : 3'h0;
    wire [31:0]  period   = isNormal ? NormPeriod[rif.rateSel]
                                     : LowPeriod[lpIndex];
    wire         wrap     = running && (count_q >= 32'(period - 32'd1));

    assign rif.powerDown      = !running;
    assign rif.lowPowerActive = isLow;
    assign rif.sampleTick     = tick_q;

    // Compare with >= so a shorter period never strands the counter
    assign count_d = (!running || wrap) ? 32'h0 : 32'(count_q + 32'd1);

    // ------------------------------------------------------------------
    // Period counter and strobe
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            count_q <= 32'h0;
            tick_q  <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            tick_q  <= wrap;
        end
    end

endmodule : arpc_rate_gen

// *** arpc_reg_bank.sv ***
// Register bank of the three-axis accelerometer: map, identifier,
// calibration restore and the power, rate and axis control register.
// Assumes the serial protocol layer hands over decoded byte events
// on the core clock; bit-level framing lives outside this block.
`timescale 1ns/1ps
module arpc_reg_bank
    import arpc_pkg::*;
#(
    // Identifier value is arbitrary
    parameter logic [7:0]     DeviceIdValue = 8'ha5,
    parameter arpc_norm_tbl_t NormPeriod    = NORM_PERIOD_DEF,
    parameter arpc_lp_tbl_t   LowPeriod     = LP_PERIOD_DEF
)
(
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             hostStart,
    input  wire logic [7:0]       hostSubAddr,
    input  wire logic             hostWrite,
    input  wire logic [7:0]       hostWrData,
    input  wire logic             hostRead,
    output logic      [7:0]       hostRdData,
    output logic                  hostRdValid,
    output logic      [5:0]       trimAddr,
    input  wire logic [7:0]       trimData,
    output logic                  restoreBusy,
    input  wire logic [2:0][7:0]  sensorData,
    output logic                  sampleTick,
    output logic                  powerDown,
    output logic                  lowPowerActive,
    output logic      [2:0]       axisMeasureEn,
    output logic      [1:0]       cutoffSel,
    output logic      [1:0]       resolutionSel,
    input  wire logic [7:0]       event1Source,
    input  wire logic [7:0]       event2Source,
    output logic                  hpFilterClear,
    output logic      [11:0][7:0] ctrlRegs
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [6:0]    ptr_q;
    logic [6:0]    ptr_d;
    logic          incr_q;
    logic [7:0]    rdData_q;
    logic          rdValid_q;
    logic          hpClear_q;
    logic [7:0]    rwReg_q [RW_COUNT];
    logic [7:0]    rwChain [RW_COUNT+1];
    logic [7:0]    axisOut_q [3];
    logic          newFlag_q [3];
    logic          ovrFlag_q [3];
    logic [7:0]    calMem [CAL_DEPTH];
    arpc_restore_t restState_q;
    logic [6:0]    loadIdx_q;
    logic          loadWr_q;
    logic [5:0]    loadWrAddr_q;
    wire  [2:0]    newBits;
    wire  [2:0]    ovrBits;

    arpc_rate_if rif ();

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    // A start in the same cycle as a byte wins; the byte is dropped
    wire       wrTaken  = !hostStart && hostWrite;
    wire       rdTaken  = !hostStart && !hostWrite && hostRead;
    wire       ptrStep  = incr_q && (wrTaken || rdTaken);
    wire       ptrRsv   = arpc_is_reserved(ptr_q);
    wire       hostCalWe = wrTaken && ptrRsv;
    wire       isIdAddr = ptr_q == ADDR_DEVICE_ID;

    // Pointer wraps within the 7-bit space
    assign ptr_d = hostStart ? hostSubAddr[6:0]
                 : ptrStep   ? 7'(ptr_q + 7'h01)
                 : ptr_q;

    // ------------------------------------------------------------------
    // Address pointer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ptr_q  <= 7'h00;
            incr_q <= 1'b0;
        end
        else
        begin
            ptr_q <= ptr_d;
            if (hostStart)
                incr_q <= hostSubAddr[SUB_INC_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Calibration restore
    // ------------------------------------------------------------------
    // Trim source answers one cycle after the address is shown
    wire restoreWe = loadWr_q
                  && arpc_is_reserved({1'b0, loadWrAddr_q});
    wire loadLast  = loadIdx_q == 7'(CAL_DEPTH - 1);

    assign trimAddr    = loadIdx_q[5:0];
    assign restoreBusy = (restState_q == RESTORE_LOADING) || loadWr_q;

    // Reset is the power-up event here; every reset reloads the trims
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            restState_q  <= RESTORE_LOADING;
            loadIdx_q    <= 7'h00;
            loadWr_q     <= 1'b0;
            loadWrAddr_q <= 6'h00;
        end
        else
        begin
            loadWr_q     <= restState_q == RESTORE_LOADING;
            loadWrAddr_q <= loadIdx_q[5:0];
            unique case (restState_q)
                RESTORE_LOADING:
                begin
                    loadIdx_q <= 7'(loadIdx_q + 7'h01);
                    if (loadLast)
                        restState_q <= RESTORE_DONE;
                end
                RESTORE_DONE:
                begin
                    loadIdx_q <= loadIdx_q;
                end
            endcase
        end
    end

    // Host writes land in cycles without a restore write: the device does not guard the trims
    always_ff @(posedge core_clk)
    begin
        if (restoreWe)
            calMem[loadWrAddr_q] <= trimData;
        else if (hostCalWe)
            calMem[ptr_q[5:0]] <= hostWrData;
    end

    // ------------------------------------------------------------------
    // Read/write control registers
    // ------------------------------------------------------------------
    assign rwChain[0] = 8'h00;

    for (genvar i = 0; i < RW_COUNT; i++)
    begin : g_rw
        wire rwHit = ptr_q == RW_ADDR[i];

        // Merge hits into a single read term
        assign rwChain[i+1] = rwChain[i] | (rwHit ? rwReg_q[i] : 8'h00);
        assign ctrlRegs[i]  = rwReg_q[i];

        always_ff @(posedge core_clk)
        begin
            if (sys_rst)
                rwReg_q[i] <= RW_RESET[i];
            else if (wrTaken && rwHit)
                rwReg_q[i] <= hostWrData;
        end
    end

    // ------------------------------------------------------------------
    // Power, rate and axis control decode
    // ------------------------------------------------------------------
    wire [7:0] ctrl1   = rwReg_q[RW_IDX_CTRL1];
    wire [1:0] rateFld = ctrl1[DR_MSB:DR_LSB];

    assign rif.powerMode  = ctrl1[PM_MSB:PM_LSB];
    assign rif.rateSel    = rateFld;
    assign sampleTick     = rif.sampleTick;
    assign powerDown      = rif.powerDown;
    assign lowPowerActive = rif.lowPowerActive;
    assign cutoffSel      = rateFld;
    assign resolutionSel  = rif.lowPowerActive ? rateFld : 2'h0;
    assign axisMeasureEn  = ctrl1[AXE_MSB:AXE_LSB]
                          & {3{!rif.powerDown}};

    arpc_rate_gen #(
        .NormPeriod (NormPeriod),
        .LowPeriod  (LowPeriod)
    ) u_rate (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .rif      (rif.gen)
    );

    // ------------------------------------------------------------------
    // Axis output registers and new-data flags
    // ------------------------------------------------------------------
    for (genvar a = 0; a < 3; a++)
    begin : g_axis
        wire outHit  = ptr_q == OUT_ADDR[a];
        wire capture = rif.sampleTick && axisMeasureEn[a];
        wire readClr = rdTaken && outHit;

        assign newBits[a] = newFlag_q[a];
        assign ovrBits[a] = ovrFlag_q[a];

        // A sample landing on the clearing read keeps its flag set
        always_ff @(posedge core_clk)
        begin
            if (sys_rst)
            begin
                axisOut_q[a] <= 8'h00;
                newFlag_q[a] <= 1'b0;
                ovrFlag_q[a] <= 1'b0;
            end
            else
            begin
                if (capture)
                    axisOut_q[a] <= sensorData[a];
                newFlag_q[a] <= capture || (newFlag_q[a] && !readClr);
                ovrFlag_q[a] <= (capture && newFlag_q[a])
                             || (ovrFlag_q[a] && !readClr);
            end
        end
    end

    wire [7:0] statusByte;
    assign statusByte[STATUS_ANY_OVR_BIT]   = |ovrBits;
    assign statusByte[STATUS_ANY_OVR_BIT-1 -: 3] = ovrBits;
    assign statusByte[STATUS_ANY_NEW_BIT]   = |newBits;
    assign statusByte[STATUS_ANY_NEW_BIT-1 -: 3] = newBits;

    // ------------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------------
    // Unmapped space and the filter-clear dummy read 00; reserved gaps read the trims
    wire [7:0] readValue =
          ptrRsv                  ? calMem[ptr_q[5:0]]
        : isIdAddr                ? DeviceIdValue
        : ptr_q == ADDR_STATUS    ? statusByte
        : ptr_q == OUT_ADDR[0]    ? axisOut_q[0]
        : ptr_q == OUT_ADDR[1]    ? axisOut_q[1]
        : ptr_q == OUT_ADDR[2]    ? axisOut_q[2]
        : ptr_q == ADDR_EV1_SRC   ? event1Source
        : ptr_q == ADDR_EV2_SRC   ? event2Source
        : rwChain[RW_COUNT];

    assign hostRdData    = rdData_q;
    assign hostRdValid   = rdValid_q;
    assign hpFilterClear = hpClear_q;

    // ------------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rdData_q  <= 8'h00;
            rdValid_q <= 1'b0;
            hpClear_q <= 1'b0;
        end
        else
        begin
            rdValid_q <= rdTaken;
            hpClear_q <= rdTaken && ptr_q == ADDR_HP_CLEAR;
            if (rdTaken)
                rdData_q <= readValue;
        end
    end

endmodule : arpc_reg_bank

// *** arpc_trim_model.sv ***
// Factory trim store behind the calibration restore port.
// Assumes the bank shows an address and samples data one cycle later.
`timescale 1ns/1ps
module arpc_trim_model
(
    input  wire logic       core_clk,
    input  wire logic [1:0] trimSalt,
    input  wire logic [5:0] trimAddr,
    output logic      [7:0] trimData
);
    // ------------------------------------------------------------------
    // Trim contents
    // ------------------------------------------------------------------
    // Salt lets a second power-up carry different trims, so a reload
    // that never happened shows up as stale data
    always_ff @(posedge core_clk)
        trimData <= {trimSalt, trimAddr};
endmodule : arpc_trim_model

// *** arpc_reg_bank_monitor.sv ***
// Port checker of the register bank: handshake, fields, restore.
// Assumes one core clock and a synchronous active high reset.
`timescale 1ns/1ps
module arpc_reg_bank_monitor
    import arpc_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             sys_rst,
    input wire logic             hostStart,
    input wire logic             hostWrite,
    input wire logic             hostRead,
    input wire logic             hostRdValid,
    input wire logic             restoreBusy,
    input wire logic             sampleTick,
    input wire logic             powerDown,
    input wire logic             lowPowerActive,
    input wire logic [2:0]       axisMeasureEn,
    input wire logic [1:0]       cutoffSel,
    input wire logic [1:0]       resolutionSel,
    input wire logic [11:0][7:0] ctrlRegs
);
    // ------------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic [2:0] pmField   = ctrlRegs[0][7:5];
    wire logic [1:0] rateField = ctrlRegs[0][4:3];
    wire logic       readTaken = hostRead & ~hostStart & ~hostWrite;

    property p_rd_ans;  readTaken |=> hostRdValid; endproperty
    property p_rd_only; hostRdValid |-> $past(readTaken); endproperty
    property p_pd;
        pmField == 3'h0 |-> powerDown && axisMeasureEn == 3'h0;
    endproperty
    property p_lp;
        lowPowerActive == (pmField >= 3'h2 && pmField <= 3'h6);
    endproperty
    property p_cut; cutoffSel == rateField; endproperty
    property p_res;
        resolutionSel == (lowPowerActive ? rateField : 2'h0);
    endproperty
    property p_axis;
        !powerDown |-> axisMeasureEn == ctrlRegs[0][2:0];
    endproperty
    property p_rst_val; $fell(sys_rst) |-> ctrlRegs[0] == 8'h07; endproperty
    // Restore must start at once and finish near 64 loads
    property p_restore;
        $fell(sys_rst) |-> ##1 restoreBusy [*8] ##[50:60] !restoreBusy;
    endproperty
    property p_tick; sampleTick |=> !sampleTick; endproperty
    // Extra cycle of margin for the registered strobe
    property p_pd_tick; powerDown [*3] |-> !sampleTick; endproperty

    a_rd_ans:  assert property (p_rd_ans)  else $error("read not answered");
    a_rd_only: assert property (p_rd_only) else $error("stray read valid");
    a_pd:      assert property (p_pd)      else $error("mode 0 not off");
    a_lp:      assert property (p_lp)      else $error("low power flag");
    a_cut:     assert property (p_cut)     else $error("cutoff select");
    a_res:     assert property (p_res)     else $error("resolution sel");
    a_axis:    assert property (p_axis)    else $error("axis enables");
    a_rst_val: assert property (p_rst_val) else $error("ctrl reset value");
    a_restore: assert property (p_restore) else $error("restore timing");
    a_tick:    assert property (p_tick)    else $error("tick too long");
    a_pd_tick: assert property (p_pd_tick) else $error("tick when off");

    c_restore: cover property ($fell(restoreBusy));
    c_lp_tick: cover property (sampleTick && lowPowerActive);
    c_read:    cover property (readTaken ##1 hostRdValid);
endmodule : arpc_reg_bank_monitor

bind arpc_reg_bank arpc_reg_bank_monitor u_mon
(
    .core_clk(core_clk), .sys_rst(sys_rst), .hostStart(hostStart),
    .hostWrite(hostWrite), .hostRead(hostRead),
    .hostRdValid(hostRdValid), .restoreBusy(restoreBusy),
    .sampleTick(sampleTick), .powerDown(powerDown),
    .lowPowerActive(lowPowerActive), .axisMeasureEn(axisMeasureEn),
    .cutoffSel(cutoffSel), .resolutionSel(resolutionSel),
    .ctrlRegs(ctrlRegs)
);

// *** tb.sv ***
// Self-checking bench of the register bank through its byte port.
// Assumes the trim model answers the restore port; short sample periods.
`timescale 1ns/1ps
module tb
    import arpc_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals, design and trim store
    // ------------------------------------------------------------------
    localparam logic [7:0] ID_VAL = 8'h5c; // Arbitrary identifier
    localparam arpc_norm_tbl_t NP = {32'd10, 32'd20, 32'd30, 32'd40};
    localparam arpc_lp_tbl_t   LP = {32'd50, 32'd60, 32'd70, 32'd80, 32'd90};
    logic core_clk, sys_rst, hostStart, hostWrite, hostRead, hpFilterClear;
    logic [7:0] hostSubAddr, hostWrData, hostRdData, trimData, ctrl;
    logic hostRdValid, restoreBusy, sampleTick, powerDown, lowPowerActive;
    logic [5:0] trimAddr;
    logic [1:0] trimSalt, cutoffSel, resolutionSel;
    logic [2:0] axisMeasureEn;
    logic [2:0][7:0] sensorData;
    logic [11:0][7:0] ctrlRegs;
    int mismatches = 0, total_checks = 0;

    arpc_reg_bank #(.DeviceIdValue(ID_VAL), .NormPeriod(NP),
        .LowPeriod(LP)) u_dut
    (
        .core_clk(core_clk), .sys_rst(sys_rst), .hostStart(hostStart),
        .hostSubAddr(hostSubAddr), .hostWrite(hostWrite),
        .hostWrData(hostWrData), .hostRead(hostRead),
        .hostRdData(hostRdData), .hostRdValid(hostRdValid),
        .trimAddr(trimAddr), .trimData(trimData),
        .restoreBusy(restoreBusy), .sensorData(sensorData),
        .sampleTick(sampleTick), .powerDown(powerDown),
        .lowPowerActive(lowPowerActive), .axisMeasureEn(axisMeasureEn),
        .cutoffSel(cutoffSel), .resolutionSel(resolutionSel),
        .event1Source(8'h3c), .event2Source(8'hc3),
        .hpFilterClear(hpFilterClear), .ctrlRegs(ctrlRegs)
    );
    arpc_trim_model u_trim
    (
        .core_clk(core_clk), .trimSalt(trimSalt),
        .trimAddr(trimAddr), .trimData(trimData)
    );

    // ------------------------------------------------------------------
    // Clock, port tasks and verdict
    // ------------------------------------------------------------------
    always #10 core_clk = ~core_clk;

    task automatic stp;
        @(posedge core_clk);
        #1;
    endtask : stp
    task automatic chk(input string n, input logic [7:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Strobes stay up between calls so back-to-back bytes are legal
    task automatic drv(input logic s, w, r, input logic [7:0] b);
        hostStart = s;
        hostWrite = w;
        hostRead = r;
        hostSubAddr = b;
        hostWrData = b;
        stp();
    endtask : drv
    task automatic rd(input logic [7:0] e);
        drv(1'b0, 1'b0, 1'b1, 8'h00);
        chk("read valid", 8'(hostRdValid), 8'h01);
        chk("read data", hostRdData, e);
    endtask : rd
    // Ticks are counted from one strobe to the next; the first is partial
    task automatic gap(input int e);
        int n;
        drv(1'b0, 1'b0, 1'b0, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do begin stp(); n++; end while (sampleTick !== 1'b1 && n < 200);
        end
        chk("tick gap", 8'(n), 8'(e));
    endtask : gap
    task automatic set_ctrl(input logic [7:0] c);
        drv(1'b1, 1'b0, 1'b0, 8'h20);
        drv(1'b0, 1'b1, 1'b0, c);
    endtask : set_ctrl
    task automatic rst_seq;
        int n;
        sys_rst = 1'b1;
        drv(1'b0, 1'b0, 1'b0, 8'h00);
        repeat (3) stp();
        sys_rst = 1'b0;
        n = 0;
        do begin stp(); n++; end while (restoreBusy !== 1'b0 && n < 100);
    endtask : rst_seq
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    initial
    begin
        #1_000_000;
        mismatches++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Scenarios; reserved space is only ever read, never written
    // ------------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        trimSalt = 2'h2;
        sensorData = {8'h33, 8'h22, 8'h11};
        rst_seq();
        for (int i = 0; i < RW_COUNT; i++)
        begin
            drv(1'b1, 1'b0, 1'b0, {1'b0, RW_ADDR[i]});
            rd(i == 0 ? 8'h07 : 8'h00);
        end
        // Read-only identifier and unmapped space ignore writes
        set_ctrl(8'h00);
        drv(1'b1, 1'b0, 1'b0, 8'h0f);
        drv(1'b0, 1'b1, 1'b0, 8'hff);
        drv(1'b1, 1'b0, 1'b0, 8'h0f);
        rd(ID_VAL);
        drv(1'b1, 1'b0, 1'b0, 8'h40);
        drv(1'b0, 1'b1, 1'b0, 8'hff);
        drv(1'b1, 1'b0, 1'b0, 8'h40);
        rd(8'h00);
        // Burst write and read with and without increment, then wrap
        drv(1'b1, 1'b0, 1'b0, 8'ha1);
        for (int i = 1; i < 4; i++) drv(1'b0, 1'b1, 1'b0, 8'(i * 17));
        drv(1'b1, 1'b0, 1'b0, 8'ha1);
        for (int i = 1; i < 4; i++) rd(8'(i * 17));
        drv(1'b1, 1'b0, 1'b0, 8'h32);
        drv(1'b0, 1'b1, 1'b0, 8'h44);
        drv(1'b0, 1'b1, 1'b0, 8'h55);
        drv(1'b1, 1'b0, 1'b0, 8'hb2);
        rd(8'h55);
        rd(8'h00);
        drv(1'b1, 1'b0, 1'b0, 8'hff);
        rd(8'h00);
        rd(8'h80);
        drv(1'b1, 1'b0, 1'b0, 8'hbf);
        rd(8'hbf);
        drv(1'b1, 1'b0, 1'b0, 8'h31);
        rd(8'h3c);
        drv(1'b1, 1'b0, 1'b0, 8'h35);
        rd(8'hc3);
        drv(1'b1, 1'b0, 1'b0, 8'h25);
        rd(8'h00);
        chk("hp clear", 8'(hpFilterClear), 8'h01);
        // Every power mode with varied rate and axis fields
        for (int p = 0; p < 8; p++)
        begin
            ctrl = {3'(p), 2'(p), 3'(p) ^ 3'h5};
            set_ctrl(ctrl);
            drv(1'b1, 1'b0, 1'b0, 8'h20);
            rd(ctrl);
            chk("off", 8'(powerDown), 8'(p == 0 || p == 7));
            chk("lp", 8'(lowPowerActive), 8'(p > 1 && p < 7));
            chk("axes", 8'(axisMeasureEn),
                (p == 0 || p == 7) ? 8'h00 : 8'(ctrl[2:0]));
            chk("cutoff", 8'(cutoffSel), 8'(p % 4));
            chk("res", 8'(resolutionSel),
                (p > 1 && p < 7) ? 8'(p % 4) : 8'h00);
        end
        for (int d = 0; d < 4; d++)
        begin
            set_ctrl({3'h1, 2'(d), 3'h7});
            gap(NP[d]);
        end
        for (int p = 2; p < 7; p++)
        begin
            set_ctrl({3'(p), 2'h0, 3'h7});
            gap(LP[p - 2]);
        end
        // Disabled axis keeps its old sample
        set_ctrl({3'h1, 2'h0, 3'h7});
        gap(NP[0]);
        set_ctrl({3'h1, 2'h0, 3'h5});
        sensorData = {8'hc3, 8'hb2, 8'ha1};
        gap(NP[0]);
        drv(1'b1, 1'b0, 1'b0, 8'h27);
        rd(8'hff);
        for (int a = 0; a < 3; a++)
        begin
            drv(1'b1, 1'b0, 1'b0, {1'b0, OUT_ADDR[a]});
            rd(a == 1 ? 8'h22 : sensorData[a]);
        end
        drv(1'b1, 1'b0, 1'b0, 8'h27);
        rd(8'h00);
        // Second power-up reloads fresh trims and defaults
        trimSalt = 2'h1;
        rst_seq();
        drv(1'b1, 1'b0, 1'b0, 8'h90);
        rd(8'h50);
        drv(1'b1, 1'b0, 1'b0, 8'h20);
        rd(8'h07);
        end_of_test();
    end
endmodule : tb
